// [hw/bsc_map.svh]
// register offsets, field positions and reset values of the bridge control
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
// register byte offsets
`define BSC_OFF_CTRL 8'h00
`define BSC_OFF_CMD 8'h04
`define BSC_OFF_STAT 8'h08
`define BSC_OFF_MASK 8'h0C
// bridge control fields
`define BSC_CTRL_LEGACY_EN 3
`define BSC_CTRL_FULL_DEC 4
`define BSC_CTRL_ABORT_MODE 5
`define BSC_CTRL_DS_RESET 6
`define BSC_CTRL_B2B_EN 7
`define BSC_CTRL_RW_MASK 16'h00F8
`define BSC_CTRL_RESET 16'h0000
// command fields
`define BSC_CMD_IO_EN 0
`define BSC_CMD_MEM_EN 1
`define BSC_CMD_RW_MASK 16'h0003
`define BSC_CMD_RESET 16'h0000
// event bits of status and mask
`define BSC_EVT_POSTED_ERR 0
`define BSC_EVT_UR_CPL 1
`define BSC_EVT_TGT_ABORT 2
`define BSC_EVT_RESET 3'h0
// legacy display windows
`define BSC_MEM_LO 32'h000A_0000
`define BSC_MEM_HI 32'h000B_FFFF
`define BSC_IO_A_LO 10'h3B0
`define BSC_IO_A_HI 10'h3BB
`define BSC_IO_B_LO 10'h3C0
`define BSC_IO_B_HI 10'h3DF
// read data on an unreported abort
`define BSC_ALL_ONES 32'hFFFF_FFFF
`endif

// [hw/bsc_pkg.sv]
// shared types of the bridge control block
package bsc_pkg;
  // one 16-bit control or command register image
  typedef logic [15:0] bsc_reg_t;
  // sticky event set
  typedef logic [2:0] bsc_evt_t;
  // bus address as seen by the decoder
  typedef logic [31:0] bsc_addr_t;
endpackage : bsc_pkg

// [hw/bsc_bridge_control.sv]
// bridge control register fields with legacy display decode and abort path
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "bsc_map.svh"
module bsc_bridge_control (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // legacy display decode request
  input wire logic dec_valid,
  input wire logic dec_from_primary,
  input wire logic dec_is_io,
  input wire logic [31:0] dec_addr,
  output logic dec_done,
  output logic fwd_downstream,
  output logic block_upstream,
  // secondary master abort on a forwarded request
  input wire logic sec_master_abort,
  input wire logic sec_abort_posted,
  input wire logic sec_abort_read,
  output logic pri_ur_completion,
  output logic abort_rdata_valid,
  output logic [31:0] abort_rdata,
  output logic abort_write_drop,
  output logic posted_abort_error,
  // unsupported request completion from the serial link
  input wire logic link_ur_completion,
  output logic sec_target_abort,
  // secondary bus controls
  output logic secondary_back_to_back_enable,
  output logic secondary_reset_out,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // legacy display address match, used for both directions
  function automatic logic legacy_match(
    input logic is_io,
    input logic [31:0] a,
    input logic full
  );
    logic lo;
    lo = 1'b0;
    if (!is_io)
    begin
      lo = (a >= `BSC_MEM_LO) && (a <= `BSC_MEM_HI);
    end
    else
    begin
      // aliases match unless full decode asks for bits 15:10
      lo = (a[31:16] == 16'h0000) &&
           (((a[9:0] >= `BSC_IO_A_LO) && (a[9:0] <= `BSC_IO_A_HI)) ||
            ((a[9:0] >= `BSC_IO_B_LO) && (a[9:0] <= `BSC_IO_B_HI))) &&
           (!full || (a[15:10] == 6'h00));
    end
    return lo;
  endfunction : legacy_match

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  bsc_pkg::bsc_reg_t ctrl; // bridge control image
  bsc_pkg::bsc_reg_t cmd; // command enables
  bsc_pkg::bsc_evt_t stat; // sticky events
  bsc_pkg::bsc_evt_t mask; // interrupt mask
  bsc_pkg::bsc_evt_t next_stat; // status after set and clear

  // field views
  logic legacy_en;
  logic full_dec;
  logic abort_mode;
  assign legacy_en = ctrl[`BSC_CTRL_LEGACY_EN];
  assign full_dec = ctrl[`BSC_CTRL_FULL_DEC];
  assign abort_mode = ctrl[`BSC_CTRL_ABORT_MODE];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------

  logic acc; // access phase, before the answer
  logic wr_go; // completing write
  logic rd_go; // completing read
  logic mapped; // address decodes to a register
  assign acc = psel && penable && !pready;
  assign wr_go = psel && penable && pready && pwrite;
  assign rd_go = psel && penable && pready && !pwrite;
  assign mapped = (paddr == `BSC_OFF_CTRL) || (paddr == `BSC_OFF_CMD) ||
                  (paddr == `BSC_OFF_STAT) || (paddr == `BSC_OFF_MASK);

  // one wait state: pready rises one edge into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc && !mapped;
      prdata <= 32'h0000_0000;
      if (acc && !pwrite)
      begin
        // unmapped reads return zero with an error
        case (paddr)
          `BSC_OFF_CTRL: prdata <= {16'h0000, ctrl};
          `BSC_OFF_CMD: prdata <= {16'h0000, cmd};
          `BSC_OFF_STAT: prdata <= {29'h0, stat};
          `BSC_OFF_MASK: prdata <= {29'h0, mask};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register: only bits 7..3 are kept, the rest read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= `BSC_CTRL_RESET;
    end
    else if (wr_go && (paddr == `BSC_OFF_CTRL))
    begin
      ctrl <= pwdata[15:0] & `BSC_CTRL_RW_MASK;
    end
  end

  // command enables that qualify legacy forwarding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd <= `BSC_CMD_RESET;
    end
    else if (wr_go && (paddr == `BSC_OFF_CMD))
    begin
      cmd <= pwdata[15:0] & `BSC_CMD_RW_MASK;
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask <= `BSC_EVT_RESET;
    end
    else if (wr_go && (paddr == `BSC_OFF_MASK))
    begin
      mask <= pwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------

  bsc_pkg::bsc_evt_t evt; // this cycle's events
  always_comb
  begin
    evt = 3'h0;
    evt[`BSC_EVT_POSTED_ERR] = sec_master_abort && sec_abort_posted &&
                               abort_mode;
    evt[`BSC_EVT_UR_CPL] = sec_master_abort && !sec_abort_posted &&
                           abort_mode;
    evt[`BSC_EVT_TGT_ABORT] = link_ur_completion && abort_mode;
  end

  // a read clears; an event in the same cycle wins over the clear
  always_comb
  begin
    next_stat = stat;
    if (rd_go && (paddr == `BSC_OFF_STAT))
    begin
      next_stat = 3'h0;
    end
    next_stat = next_stat | evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat <= `BSC_EVT_RESET;
    end
    else
    begin
      stat <= next_stat;
    end
  end

  // level interrupt, registered from next_stat so it changes on the same edge as the status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(next_stat & mask);
    end
  end

  // ----------------------------------------------------------------
  // secondary bus controls
  // ----------------------------------------------------------------

  // registered copies so the pins never glitch on bus writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      secondary_back_to_back_enable <= 1'b0;
      secondary_reset_out <= 1'b0;
    end
    else
    begin
      secondary_back_to_back_enable <= ctrl[`BSC_CTRL_B2B_EN];
      secondary_reset_out <= ctrl[`BSC_CTRL_DS_RESET];
    end
  end

  // ----------------------------------------------------------------
  // legacy display decode
  // ----------------------------------------------------------------

  logic hit; // address is a legacy display address
  logic space_en; // matching command enable for this space
  assign hit = legacy_match(dec_is_io, dec_addr, full_dec);
  assign space_en = dec_is_io ? cmd[`BSC_CMD_IO_EN] :
                                cmd[`BSC_CMD_MEM_EN];

  // base and limit windows are not consulted here at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_done <= 1'b0;
      fwd_downstream <= 1'b0;
      block_upstream <= 1'b0;
    end
    else
    begin
      dec_done <= dec_valid;
      fwd_downstream <= dec_valid && dec_from_primary && legacy_en &&
                        hit && space_en;
      block_upstream <= dec_valid && !dec_from_primary && legacy_en &&
                        hit;
    end
  end

  // ----------------------------------------------------------------
  // abort handling
  // ----------------------------------------------------------------

  // results are one-cycle pulses, one edge after the cause
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pri_ur_completion <= 1'b0;
      abort_rdata_valid <= 1'b0;
      abort_rdata <= 32'h0000_0000;
      abort_write_drop <= 1'b0;
      posted_abort_error <= 1'b0;
      sec_target_abort <= 1'b0;
    end
    else
    begin
      pri_ur_completion <= evt[`BSC_EVT_UR_CPL];
      posted_abort_error <= evt[`BSC_EVT_POSTED_ERR];
      sec_target_abort <= evt[`BSC_EVT_TGT_ABORT];
      // silent mode: fill reads with ones, drop writes
      abort_rdata_valid <= sec_master_abort && sec_abort_read &&
                           !abort_mode;
      abort_rdata <= (sec_master_abort && sec_abort_read && !abort_mode) ?
                     `BSC_ALL_ONES : 32'h0000_0000;
      abort_write_drop <= sec_master_abort && !sec_abort_read &&
                          !abort_mode;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_b2b;
    ##1 secondary_back_to_back_enable == $past(ctrl[7]);
  endproperty
  a_b2b: assert property (p_b2b)
    else $error("back-to-back output does not follow field");

  property p_sreset;
    wr_go && paddr == 8'h00 |=> ##1 secondary_reset_out == $past(pwdata[6], 2);
  endproperty
  a_sreset: assert property (p_sreset)
    else $error("secondary reset output not set by write");

  property p_ones;
    sec_master_abort && sec_abort_read && !ctrl[5] |=>
      abort_rdata_valid && abort_rdata == 32'hFFFF_FFFF && !pri_ur_completion;
  endproperty
  a_ones: assert property (p_ones)
    else $error("silent read abort did not return all ones");

  property p_ur;
    sec_master_abort && !sec_abort_posted && ctrl[5] |=>
      pri_ur_completion && !abort_rdata_valid;
  endproperty
  a_ur: assert property (p_ur)
    else $error("master abort did not produce unsupported request");

  property p_tabort;
    sec_target_abort |-> $past(link_ur_completion) && $past(ctrl[5]);
  endproperty
  a_tabort: assert property (p_tabort)
    else $error("target abort without cause");

  property p_posted;
    sec_master_abort && sec_abort_posted |=>
      posted_abort_error == $past(ctrl[5]) && stat[0] == $past(ctrl[5]) ||
      stat[0];
  endproperty
  a_posted: assert property (p_posted)
    else $error("posted write abort reporting wrong");

  property p_alias;
    dec_valid && dec_from_primary && dec_is_io && ctrl[3] && !ctrl[4] &&
      cmd[0] && dec_addr[31:16] == 16'h0000 && dec_addr[9:0] == 10'h3C0
      |=> fwd_downstream;
  endproperty
  a_alias: assert property (p_alias)
    else $error("alias of legacy I/O address not forwarded");

  property p_full;
    dec_valid && dec_is_io && ctrl[4] && dec_addr[15:10] != 6'h00
      |=> !fwd_downstream && !block_upstream;
  endproperty
  a_full: assert property (p_full)
    else $error("full decode let an alias through");

  property p_dir;
    fwd_downstream || block_upstream |->
      $past(ctrl[3]) && $past(dec_valid) &&
      (fwd_downstream == $past(dec_from_primary));
  endproperty
  a_dir: assert property (p_dir)
    else $error("legacy forward direction wrong");

  property p_mem;
    dec_valid && !dec_is_io && (dec_addr < 32'h000A_0000 ||
      dec_addr > 32'h000B_FFFF) |=> !fwd_downstream && !block_upstream;
  endproperty
  a_mem: assert property (p_mem)
    else $error("memory outside legacy window matched");

  property p_io;
    dec_valid && dec_is_io && dec_addr[31:16] != 16'h0000
      |=> !fwd_downstream && !block_upstream;
  endproperty
  a_io: assert property (p_io)
    else $error("I/O above 64K matched");

  property p_en;
    fwd_downstream |-> $past(dec_is_io) ? $past(cmd[0]) : $past(cmd[1]);
  endproperty
  a_en: assert property (p_en)
    else $error("forwarded without space enable");

  property p_clr;
    rd_go && paddr == 8'h08 && evt == 3'h0 |=> stat == 3'h0 ##1 1'b1;
  endproperty
  a_clr: assert property (p_clr)
    else $error("status read did not clear");

endmodule : bsc_bridge_control
`default_nettype wire

// [tb/bsc_far_side.sv]
// far-side model: secondary agents and serial link feeding the block
`timescale 1ns/10ps
`default_nettype none
module bsc_far_side (
  // clock
  input wire logic pclk,
  // decode requests
  output logic dec_valid,
  output logic dec_from_primary,
  output logic dec_is_io,
  output logic [31:0] dec_addr,
  // abort and completion events
  output logic sec_master_abort,
  output logic sec_abort_posted,
  output logic sec_abort_read,
  output logic link_ur_completion
);
  // ----------------------------------------
  // idle values at time zero
  // ----------------------------------------
  initial
  begin
    dec_valid = 1'h0;
    dec_from_primary = 1'h0;
    dec_is_io = 1'h0;
    dec_addr = 32'h0;
    sec_master_abort = 1'h0;
    sec_abort_posted = 1'h0;
    sec_abort_read = 1'h0;
    link_ur_completion = 1'h0;
  end
  // one decode request, then the address lines carry junk
  task automatic decode(logic fp, logic io, logic [31:0] a);
    @(posedge pclk);
    dec_valid <= 1'h1;
    dec_from_primary <= fp;
    dec_is_io <= io;
    dec_addr <= a;
    @(posedge pclk);
    dec_valid <= 1'h0;
    dec_addr <= ~a;
    dec_from_primary <= ~fp;
  endtask : decode
  // kind 0 read, 1 write, 2 posted write, 3 link completion
  task automatic abort(logic [1:0] kind);
    @(posedge pclk);
    sec_master_abort <= (kind != 2'h3);
    sec_abort_read <= (kind == 2'h0);
    sec_abort_posted <= (kind == 2'h2);
    link_ur_completion <= (kind == 2'h3);
    @(posedge pclk);
    sec_master_abort <= 1'h0;
    link_ur_completion <= 1'h0;
    // qualifiers mean nothing now, so they are not kept tidy
    sec_abort_read <= (kind != 2'h0);
    sec_abort_posted <= (kind != 2'h2);
  endtask : abort
endmodule : bsc_far_side
`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the bridge control block
`timescale 1ns/10ps
`default_nettype none
`include "bsc_map.svh"
module tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, dec_addr, abort_rdata;
  logic dec_valid, dec_from_primary, dec_is_io, dec_done;
  logic fwd_downstream, block_upstream, sec_master_abort;
  logic sec_abort_posted, sec_abort_read, pri_ur_completion;
  logic abort_rdata_valid, abort_write_drop, posted_abort_error;
  logic link_ur_completion, sec_target_abort, irq;
  logic secondary_back_to_back_enable, secondary_reset_out;
  int failures, comparisons, cycles;
  // design and far side, joined by name
  bsc_bridge_control DUT (
    .pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .dec_valid(dec_valid), .dec_from_primary(dec_from_primary),
    .dec_is_io(dec_is_io), .dec_addr(dec_addr), .dec_done(dec_done),
    .fwd_downstream(fwd_downstream), .block_upstream(block_upstream),
    .sec_master_abort(sec_master_abort),
    .sec_abort_posted(sec_abort_posted),
    .sec_abort_read(sec_abort_read),
    .pri_ur_completion(pri_ur_completion),
    .abort_rdata_valid(abort_rdata_valid), .abort_rdata(abort_rdata),
    .abort_write_drop(abort_write_drop),
    .posted_abort_error(posted_abort_error),
    .link_ur_completion(link_ur_completion),
    .sec_target_abort(sec_target_abort),
    .secondary_back_to_back_enable(secondary_back_to_back_enable),
    .secondary_reset_out(secondary_reset_out),
    .irq(irq)
  );
  bsc_far_side far (
    .pclk(pclk),
    .dec_valid(dec_valid), .dec_from_primary(dec_from_primary),
    .dec_is_io(dec_is_io), .dec_addr(dec_addr),
    .sec_master_abort(sec_master_abort),
    .sec_abort_posted(sec_abort_posted),
    .sec_abort_read(sec_abort_read),
    .link_ur_completion(link_ur_completion)
  );
  // ----------------------------------------
  // clock, timeout and checking helpers
  // ----------------------------------------
  initial
  begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  // the whole run needs under two hundred cycles; this cuts a hang
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      final_report();
    end
  end
  function automatic logic [31:0] b(logic x);
    return {31'h0, x};
  endfunction : b
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // one apb transfer; waits for pready, only the bench timeout ends it
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk("pready", b(pready), 32'h1);
  endtask : apb
  // let registered outputs follow a write, then settle
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  // code bits: from primary, is io, expect forward, expect block
  task automatic dchk(logic [3:0] c, logic [31:0] a);
    far.decode(c[3], c[2], a);
    #1;
    chk("dec_done", b(dec_done), 32'h1);
    chk("forward", b(fwd_downstream), b(c[1]));
    chk("block", b(block_upstream), b(c[0]));
  endtask : dchk
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'h0, `BSC_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped err", b(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    chk("b2b", b(secondary_back_to_back_enable), 32'h0);
    chk("sec reset", b(secondary_reset_out), 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ctrl();
    apb(1'h1, `BSC_OFF_CTRL, 32'hFFFF_FFFF);
    apb(1'h0, `BSC_OFF_CTRL, 32'h0);
    chk("ctrl rw", rd, 32'h0000_00F8);
    settle();
    chk("b2b on", b(secondary_back_to_back_enable), 32'h1);
    chk("reset on", b(secondary_reset_out), 32'h1);
    apb(1'h1, `BSC_OFF_CTRL, 32'h0000_0040);
    settle();
    chk("b2b off", b(secondary_back_to_back_enable), 32'h0);
    chk("reset held", b(secondary_reset_out), 32'h1);
    apb(1'h1, `BSC_OFF_CTRL, 32'h0);
    settle();
    chk("reset off", b(secondary_reset_out), 32'h0);
    $display("test control done");
  endtask : t_ctrl
  task automatic t_mode0();
    apb(1'h1, `BSC_OFF_MASK, 32'h0000_0007);
    far.abort(2'h0);
    #1;
    chk("fill valid", b(abort_rdata_valid), 32'h1);
    chk("fill data", abort_rdata, 32'hFFFF_FFFF);
    chk("no ur", b(pri_ur_completion), 32'h0);
    far.abort(2'h1);
    #1;
    chk("write drop", b(abort_write_drop), 32'h1);
    far.abort(2'h2);
    #1;
    chk("posted quiet", b(posted_abort_error), 32'h0);
    far.abort(2'h3);
    #1;
    chk("no tabort", b(sec_target_abort), 32'h0);
    chk("irq quiet", b(irq), 32'h0);
    apb(1'h0, `BSC_OFF_STAT, 32'h0);
    chk("stat quiet", rd, 32'h0);
    $display("test mode 0 done");
  endtask : t_mode0
  task automatic t_mode1();
    apb(1'h1, `BSC_OFF_CTRL, 32'h0000_0020);
    far.abort(2'h0);
    #1;
    chk("ur", b(pri_ur_completion), 32'h1);
    chk("no fill", b(abort_rdata_valid), 32'h0);
    far.abort(2'h2);
    #1;
    chk("posted err", b(posted_abort_error), 32'h1);
    far.abort(2'h3);
    #1;
    chk("tabort", b(sec_target_abort), 32'h1);
    chk("irq set", b(irq), 32'h1);
    apb(1'h0, `BSC_OFF_STAT, 32'h0);
    chk("stat", rd, 32'h0000_0007);
    settle();
    chk("irq clear", b(irq), 32'h0);
    apb(1'h1, `BSC_OFF_MASK, 32'h0);
    far.abort(2'h3);
    settle();
    chk("irq masked", b(irq), 32'h0);
    apb(1'h1, `BSC_OFF_MASK, 32'h0000_0004);
    settle();
    chk("irq unmask", b(irq), 32'h1);
    apb(1'h0, `BSC_OFF_STAT, 32'h0);
    chk("stat ta", rd, 32'h0000_0004);
    $display("test mode 1 done");
  endtask : t_mode1
  task automatic t_decode();
    apb(1'h1, `BSC_OFF_CMD, 32'h0000_0003);
    apb(1'h1, `BSC_OFF_CTRL, 32'h0000_0008);
    dchk(4'hA, 32'h000A_0000);
    dchk(4'hA, 32'h000B_FFFF);
    dchk(4'h8, 32'h0009_FFFF);
    dchk(4'h8, 32'h000C_0000);
    dchk(4'hE, 32'h0000_03B0);
    dchk(4'hE, 32'h0000_03BB);
    dchk(4'hC, 32'h0000_03BC);
    dchk(4'hE, 32'h0000_03C0);
    dchk(4'hE, 32'h0000_03DF);
    dchk(4'hC, 32'h0000_03E0);
    dchk(4'hC, 32'h0001_03B0);
    dchk(4'hE, 32'h0000_FFC0);
    dchk(4'h1, 32'h000A_0000);
    apb(1'h1, `BSC_OFF_CTRL, 32'h0000_0018);
    dchk(4'hE, 32'h0000_03C0);
    dchk(4'hC, 32'h0000_07C0);
    apb(1'h1, `BSC_OFF_CMD, 32'h0);
    dchk(4'h8, 32'h000A_0000);
    dchk(4'h5, 32'h0000_03C0);
    apb(1'h1, `BSC_OFF_CMD, 32'h0000_0003);
    apb(1'h1, `BSC_OFF_CTRL, 32'h0000_0010);
    dchk(4'hC, 32'h0000_03C0);
    $display("test decode done");
  endtask : t_decode
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_ctrl();
    t_mode0();
    t_mode1();
    t_decode();
    final_report();
  end
endmodule : tb
`default_nettype wire
